// >>> rtl/dims_defines.vh
// Purpose: Constants shared by the input mode sequencer and its sample FIFO.
// Assumes: Included by its bare name from rtl/ design files.
// Notes:   Definitions only; no logic lives here.

`ifndef DIMS_DEFINES_VH
`define DIMS_DEFINES_VH

// ************************************************************
// Widths and depths
// ************************************************************
`define DIMS_SAMPLE_W      14
`define DIMS_PAIR_W        28
`define DIMS_FIFO_DEPTH    32
`define DIMS_FIFO_AW       5
`define DIMS_READY_LIMIT   6'd28
`define DIMS_SYNC_W        65
`define DIMS_ALL_ONES      14'h3fff
`define DIMS_MIDSCALE      14'h2000

// ************************************************************
// Register map (byte addresses) and fields
// ************************************************************
`define DIMS_ADDR_CTRL     4'h0
`define DIMS_ADDR_STATUS   4'h4
`define DIMS_ADDR_COUNT    4'h8
`define DIMS_CTRL_RESET    2'h1
`define DIMS_CTRL_EN_BIT   0
`define DIMS_CTRL_DLL_BIT  1
`define DIMS_ST_PAIR_BIT   0
`define DIMS_ST_OVF_BIT    1
`define DIMS_ST_UNDR_BIT   2
`define DIMS_RESP_OKAY     2'h0
`define DIMS_RESP_SLVERR   2'h2

`endif

// >>> rtl/dims_fifo.v
// Purpose: Sample-pair FIFO between the input ports and the sequencer.
// Assumes: One clock; writer and reader obey valid/ready.
// Notes:   Storage is flip-flops; level reports the words held.

`timescale 1ns/1ps
`default_nettype none

module dims_fifo #(
	parameter WIDTH = 28,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset.
	input  wire             clk,
	input  wire             resetn,
	// Fill side.
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Drain side.
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	// Fill level.
	output wire [AW:0]      level
);

	localparam [AW:0] FULL_COUNT = DEPTH;

	reg [WIDTH-1:0] mem [0:DEPTH-1];  // Word storage.
	reg [AW-1:0]    wr_ptr_reg;       // Next slot to fill.
	reg [AW-1:0]    rd_ptr_reg;       // Oldest word.
	reg [AW:0]      count_reg;        // Words held.

	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;

	assign in_ready  = (count_reg != FULL_COUNT);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_reg];
	assign level     = count_reg;

	// ************************************************************
	// Storage write; no reset, contents are qualified by count.
	// ************************************************************
	always @(posedge clk)
	begin
		if (do_wr)
		begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// ************************************************************
	// Pointers and count.
	// ************************************************************
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_wr)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			// Simultaneous push and pop leave the count unchanged.
			if (do_wr && !do_rd)
			begin
				count_reg <= count_reg + 1'b1;
			end
			else if (do_rd && !do_wr)
			begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule // dims_fifo

`default_nettype wire

// >>> rtl/dims_sequencer.v
// Purpose: Merges two 14-bit differential sample ports into one DAC stream.
// Assumes: 50 MHz clk, async active-low resetn, AXI4-Lite register access.
// Notes:   One output sample per clock; one FIFO pair yields two samples.
//
// Summary of operation
// - Interleave mode outputs A0,B0,A1,B1 alternately.
// - Repeat mode outputs each A twice.
// - Invert mode outputs A then negated A.
// - Zero-stuff mode outputs A then zero.
// - Restart pin holds loop in reset.
// - Invert pin flips loop target clock relation.
// - Level pin high selects LVDS output clock.
// - All-ones code gives true full scale.
// - All-zeros code gives complement full scale.

`timescale 1ns/1ps
`default_nettype none
`include "dims_defines.vh"

module dims_sequencer (
	// Clock and reset.
	input  wire        clk,
	input  wire        resetn,
	// AXI4-Lite write channels.
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Differential sample ports and flow control.
	input  wire [13:0] port_a_true,
	input  wire [13:0] port_a_comp,
	input  wire [13:0] port_b_true,
	input  wire [13:0] port_b_comp,
	input  wire        port_valid,
	output wire        port_ready,
	// Static control pins.
	input  wire        interleave_sel,
	input  wire        single_port_repeat_sel,
	input  wire        single_port_invert_sel,
	input  wire        single_port_zero_stuff_sel,
	input  wire        loop_restart,
	input  wire        clock_invert_sel,
	input  wire        out_clock_level_sel,
	input  wire        sleep,
	// Converter core controls.
	output wire [13:0] current_out_true,
	output wire [13:0] current_out_comp,
	output wire        sample_valid,
	output wire        dll_reset,
	output wire        dll_target_invert,
	output wire        out_clock_lvds_en,
	output wire        low_power
);

	// Sequencer phases.
	localparam PH_FIRST  = 1'b0;
	localparam PH_SECOND = 1'b1;

	// ************************************************************
	// Functions
	// ************************************************************

	// Maps a byte address to a register index; 3 means unmapped.
	function [1:0] reg_index;
		input [3:0] addr;
		begin
			case (addr)
				`DIMS_ADDR_CTRL:   reg_index = 2'd0;
				`DIMS_ADDR_STATUS: reg_index = 2'd1;
				`DIMS_ADDR_COUNT:  reg_index = 2'd2;
				default:           reg_index = 2'd3;
			endcase
		end
	endfunction

	// True when a pair carries exact complements on every bit.
	function pair_ok;
		input [13:0] t;
		input [13:0] c;
		begin
			pair_ok = ((t ^ c) == `DIMS_ALL_ONES);
		end
	endfunction

	// ************************************************************
	// Pin synchronisers
	// ************************************************************

	// Every pin passes two flops; only the second rank is read.
	// Skew across a bus is not corrected, so the source must hold
	// each pair steady for at least three clocks.
	reg [64:0] sync1_reg;  // First rank.
	reg [64:0] sync2_reg;  // Second rank, the only one read.

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_reg <= {`DIMS_SYNC_W{1'b0}};
			sync2_reg <= {`DIMS_SYNC_W{1'b0}};
		end
		else
		begin
			sync1_reg <= {port_valid, port_b_comp, port_b_true, port_a_comp,
				port_a_true, interleave_sel, single_port_repeat_sel,
				single_port_invert_sel, single_port_zero_stuff_sel,
				loop_restart, clock_invert_sel, out_clock_level_sel, sleep};
			sync2_reg <= sync1_reg;
		end
	end

	wire        sleep_s   = sync2_reg[0];      // Sleep request.
	wire        level_s   = sync2_reg[1];      // Output clock level.
	wire        cinv_s    = sync2_reg[2];      // Target clock inversion.
	wire        restart_s = sync2_reg[3];      // Loop restart.
	wire [3:0]  mode_s    = sync2_reg[7:4];    // {inter,rep,inv,zs}.
	wire [13:0] a_t       = sync2_reg[21:8];   // Bit 13 is the MSB.
	wire [13:0] a_c       = sync2_reg[35:22];
	wire [13:0] b_t       = sync2_reg[49:36];
	wire [13:0] b_c       = sync2_reg[63:50];
	wire        in_valid  = sync2_reg[64];

	// Mode must be one-hot; anything else parks the output.
	wire mode_ok = (mode_s != 4'h0) && ((mode_s & (mode_s - 4'h1)) == 4'h0);

	// Port B is only checked where interleave uses it.
	wire pair_bad = in_valid && (!pair_ok(a_t, a_c) ||
		(mode_s[3] && !pair_ok(b_t, b_c)));

	// ************************************************************
	// Registers and bus state
	// ************************************************************
	reg [1:0]  ctrl_reg;        // Enable and software loop reset.
	reg [2:0]  sticky_reg;      // Pair error, overflow, underrun.
	reg [31:0] count_reg;       // Samples emitted.
	reg        awready_reg;     // Write address ready.
	reg        wready_reg;      // Write data ready.
	reg        aw_held_reg;     // Address taken, awaiting data.
	reg        w_held_reg;      // Data taken, awaiting address.
	reg [3:0]  awaddr_reg;      // Held write address.
	reg [31:0] wdata_reg;       // Held write data.
	reg [3:0]  wstrb_reg;       // Held byte enables.
	reg        bvalid_reg;      // Write response valid.
	reg [1:0]  bresp_reg;       // Write response code.
	reg        arready_reg;     // Read address ready.
	reg        rvalid_reg;      // Read data valid.
	reg [1:0]  rresp_reg;       // Read response code.
	reg [31:0] rdata_reg;       // Read data.

	// ************************************************************
	// Sample path state
	// ************************************************************
	reg        phase_reg;       // Which half of a pair is next.
	reg        started_reg;     // First pair has been consumed.
	reg [13:0] hold_a_reg;      // Port A sample of current pair.
	reg [13:0] hold_b_reg;      // Port B sample of current pair.
	reg [13:0] code_reg;        // Code on the true output.
	reg [13:0] code_comp_reg;   // Code on the complement output.
	reg        valid_reg;       // A converted sample is on the outputs.
	reg        ready_reg;       // Space advertised to the source.
	reg        dll_rst_reg;     // Loop reset.
	reg        cinv_reg;        // Loop target inversion.
	reg        lvds_reg;        // Output clock at LVDS level.
	reg        sleep_reg;       // Low-power state.

	reg        phase_next;
	reg [13:0] code_next;
	reg        valid_next;

	wire [27:0] fifo_out;
	wire        fifo_out_valid;
	wire        fifo_in_ready;
	wire [5:0]  fifo_level;

	// Conversion runs only when enabled, awake and mode is legal.
	wire running = ctrl_reg[`DIMS_CTRL_EN_BIT] && !sleep_s && mode_ok;
	wire pop     = (phase_reg == PH_FIRST) && running && fifo_out_valid;

	// ************************************************************
	// Sample FIFO
	// ************************************************************
	dims_fifo #(
		.WIDTH (`DIMS_PAIR_W),
		.DEPTH (`DIMS_FIFO_DEPTH),
		.AW    (`DIMS_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_data   ({b_t, a_t}),
		.in_valid  (in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.level     (fifo_level)
	);

	// ************************************************************
	// Sequencer next state
	// ************************************************************

	// The first half of a pair is always port A; the second half
	// depends on the mode. Offset binary: zero is midscale and the
	// negation is the two's complement of the code.
	always @*
	begin
		phase_next = phase_reg;
		code_next  = `DIMS_MIDSCALE;
		valid_next = 1'b0;
		case (phase_reg)
			PH_FIRST:
			begin
				if (pop)
				begin
					code_next  = fifo_out[13:0];
					valid_next = 1'b1;
					phase_next = PH_SECOND;
				end
			end
			PH_SECOND:
			begin
				valid_next = 1'b1;
				phase_next = PH_FIRST;
				case (mode_s)
					4'h8:    code_next = hold_b_reg;
					4'h4:    code_next = hold_a_reg;
					4'h2:    code_next = 14'h0000 - hold_a_reg;
					4'h1:    code_next = `DIMS_MIDSCALE;
					default: code_next = `DIMS_MIDSCALE;
				endcase
			end
			default:
			begin
				phase_next = PH_FIRST;
			end
		endcase
	end

	// ************************************************************
	// Sequencer and converter control registers
	// ************************************************************
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase_reg     <= PH_FIRST;
			started_reg   <= 1'b0;
			hold_a_reg    <= 14'h0000;
			hold_b_reg    <= 14'h0000;
			code_reg      <= `DIMS_MIDSCALE;
			code_comp_reg <= ~`DIMS_MIDSCALE;
			valid_reg     <= 1'b0;
			ready_reg     <= 1'b0;
			dll_rst_reg   <= 1'b1;
			cinv_reg      <= 1'b0;
			lvds_reg      <= 1'b0;
			sleep_reg     <= 1'b0;
		end
		else
		begin
			phase_reg     <= phase_next;
			code_reg      <= code_next;
			code_comp_reg <= ~code_next;
			valid_reg     <= valid_next;
			if (pop)
			begin
				hold_a_reg  <= fifo_out[13:0];
				hold_b_reg  <= fifo_out[27:14];
				started_reg <= 1'b1;
			end
			// Margin covers the two sync ranks and this flop.
			ready_reg   <= (fifo_level <= `DIMS_READY_LIMIT);
			dll_rst_reg <= restart_s | ctrl_reg[`DIMS_CTRL_DLL_BIT];
			cinv_reg    <= cinv_s;
			lvds_reg    <= level_s;
			sleep_reg   <= sleep_s;
		end
	end

	// ************************************************************
	// AXI4-Lite write path
	// ************************************************************

	// Address and data are taken in any order; the register is
	// written once both are held, with the response raised in the same clock.
	wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
	wire [1:0] wr_idx = reg_index(awaddr_reg);
	wire wr_ctrl = wr_go && (wr_idx == 2'd0) && wstrb_reg[0];
	wire wr_stat = wr_go && (wr_idx == 2'd1) && wstrb_reg[0];

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 4'h0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `DIMS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				awaddr_reg  <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg)
			begin
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				w_held_reg <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (wr_go)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (wr_idx == 2'd3) ? `DIMS_RESP_SLVERR : `DIMS_RESP_OKAY;
			end
			// Readies return only after the response is taken.
			if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Software registers and sticky status
	// ************************************************************

	// Status flags clear by writing one; a new event in the same
	// clock as the clear wins, so no event is lost.
	wire [2:0] st_set = {running && (phase_reg == PH_FIRST) && !fifo_out_valid && started_reg,
		in_valid && !fifo_in_ready, pair_bad};
	wire [2:0] st_clr = wr_stat ? wdata_reg[2:0] : 3'h0;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_reg   <= `DIMS_CTRL_RESET;
			sticky_reg <= 3'h0;
			count_reg  <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_reg <= wdata_reg[1:0];
			end
			sticky_reg <= (sticky_reg & ~st_clr) | st_set;
			// The counter wraps; a write clears it.
			if (wr_go && (wr_idx == 2'd2))
			begin
				count_reg <= 32'h0000_0000;
			end
			else if (valid_next)
			begin
				count_reg <= count_reg + 32'h0000_0001;
			end
		end
	end

	// ************************************************************
	// AXI4-Lite read path
	// ************************************************************
	wire [31:0] status_word = {18'h00000, fifo_level, 2'h0, sleep_reg,
		dll_rst_reg, !mode_ok, sticky_reg};

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `DIMS_RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
		end
		else
		begin
			if (s_axi_arvalid && arready_reg)
			begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rresp_reg   <= `DIMS_RESP_OKAY;
				case (reg_index(s_axi_araddr))
					2'd0:    rdata_reg <= {30'h0, ctrl_reg};
					2'd1:    rdata_reg <= status_word;
					2'd2:    rdata_reg <= count_reg;
					default:
					begin
						rdata_reg <= 32'h0000_0000;
						rresp_reg <= `DIMS_RESP_SLVERR;
					end
				endcase
			end
			if (rvalid_reg && s_axi_rready)
			begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign s_axi_awready     = awready_reg;
	assign s_axi_wready      = wready_reg;
	assign s_axi_bresp       = bresp_reg;
	assign s_axi_bvalid      = bvalid_reg;
	assign s_axi_arready     = arready_reg;
	assign s_axi_rdata       = rdata_reg;
	assign s_axi_rresp       = rresp_reg;
	assign s_axi_rvalid      = rvalid_reg;
	assign port_ready        = ready_reg;
	assign current_out_true  = code_reg;
	assign current_out_comp  = code_comp_reg;
	assign sample_valid      = valid_reg;
	assign dll_reset         = dll_rst_reg;
	assign dll_target_invert = cinv_reg;
	assign out_clock_lvds_en = lvds_reg;
	assign low_power         = sleep_reg;

endmodule // dims_sequencer

`default_nettype wire

// >>> tb/dims_sequencer_sva.sv
// Purpose: Port-level checks for dims_sequencer.
// Assumes: Bound to every instance of dims_sequencer.
// Notes:   Pin checks wait for the synchronisers.
`timescale 1ns/1ps
`default_nettype none
module dims_sequencer_sva (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        resetn,
	// Mode and control pins.
	input wire logic        single_port_repeat_sel,
	input wire logic        single_port_invert_sel,
	input wire logic        single_port_zero_stuff_sel,
	input wire logic        loop_restart,
	input wire logic        clock_invert_sel,
	input wire logic        out_clock_level_sel,
	input wire logic        sleep,
	// Converter core side.
	input wire logic [13:0] current_out_true,
	input wire logic [13:0] current_out_comp,
	input wire logic        sample_valid,
	input wire logic        dll_reset,
	input wire logic        dll_target_invert,
	input wire logic        out_clock_lvds_en,
	input wire logic        low_power
);
	// ************************************************************
	// Helper state
	// ************************************************************
	logic [2:0] up_cnt; // Edges since reset release, saturating at four.
	logic       second; // High while the second sample of a pair is shown.
	// Pin checks start four edges after reset.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			up_cnt <= 3'h0;
			second <= 1'b0;
		end
		else
		begin
			up_cnt <= (up_cnt == 3'h4) ? up_cnt : up_cnt + 3'h1;
			second <= sample_valid ? ~second : second;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_comp; current_out_comp == ~current_out_true; endproperty
	property p_repeat; sample_valid && second && single_port_repeat_sel
		|-> current_out_true == $past(current_out_true); endproperty
	property p_invert; sample_valid && second && single_port_invert_sel
		|-> current_out_true == 14'h0 - $past(current_out_true); endproperty
	property p_zero; sample_valid && second && single_port_zero_stuff_sel
		|-> current_out_true == 14'h2000; endproperty
	property p_restart; up_cnt == 3'h4 && $past(loop_restart, 3) |-> dll_reset; endproperty
	property p_clk_inv; up_cnt == 3'h4 |-> dll_target_invert == $past(clock_invert_sel, 3);
	endproperty
	property p_lvds; up_cnt == 3'h4 |-> out_clock_lvds_en == $past(out_clock_level_sel, 3);
	endproperty
	property p_sleep_pin; up_cnt == 3'h4 |-> low_power == $past(sleep, 3); endproperty
	property p_sleep_out; low_power && $past(low_power, 3)
		|-> !sample_valid && current_out_true == 14'h2000; endproperty
	a_comp: assert property (p_comp)
		else $error("comp output not inverse");
	a_repeat: assert property (p_repeat)
		else $error("repeat mismatch");
	a_invert: assert property (p_invert)
		else $error("invert mismatch");
	a_zero: assert property (p_zero)
		else $error("zero stuff mismatch");
	a_restart: assert property (p_restart)
		else $error("loop reset not held");
	a_clk_inv: assert property (p_clk_inv)
		else $error("target inversion wrong");
	a_lvds: assert property (p_lvds)
		else $error("clock level wrong");
	a_sleep_pin: assert property (p_sleep_pin)
		else $error("low power wrong");
	a_sleep_out: assert property (p_sleep_out)
		else $error("sample while asleep");
	c_invert: cover property (sample_valid && second && single_port_invert_sel);
	c_zero: cover property (sample_valid && second && single_port_zero_stuff_sel);
	c_sleep: cover property (low_power && sleep);
endmodule // dims_sequencer_sva
bind dims_sequencer dims_sequencer_sva i_dims_sequencer_sva (.*);
`default_nettype wire

// >>> tb/dims_sequencer_test.sv
// Purpose: Self-checking bench for dims_sequencer.
// Assumes: 50 MHz clock; the source model drives the sample ports.
// Notes:   Fixed-seed random pairs plus end codes.
`timescale 1ns/1ps
`default_nettype none
`include "dims_defines.vh"
module dims_sequencer_test;
	logic        clk = 1'b0, resetn = 1'b0;             // Clock and reset.
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [13:0]  port_a_true, port_a_comp, port_b_true, port_b_comp;
	wire         port_valid, port_ready, sample_valid, dll_reset;
	wire         dll_target_invert, out_clock_lvds_en, low_power;
	wire [13:0]  current_out_true, current_out_comp;
	logic        interleave_sel = 1'b1, single_port_repeat_sel = 1'b0;
	logic        single_port_invert_sel = 1'b0, single_port_zero_stuff_sel = 1'b0;
	logic        loop_restart = 1'b0, clock_invert_sel = 1'b0;
	logic        out_clock_level_sel = 1'b0, sleep = 1'b0;
	logic [13:0] expq[$];     // Expected codes in order.
	logic        hold_out = 1'b0; // No sample may appear.
	int          num_errors = 0, samples_checked = 0, nsamp = 0, m, i;
	logic [31:0] seed, r;
	dims_sequencer i_dims_sequencer (.*);
	dims_source_model i_dims_source_model (.*);
	// ************************************************************
	// Helpers
	// ************************************************************
	initial
		forever #10 clk = ~clk;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Second sample of a pair for each mode; zero is midscale in offset binary.
	function automatic logic [13:0] second_of(input int md, input logic [13:0] a, b);
		case (md)
			0: return b;
			1: return a;
			2: return 14'h0 - a;
			default: return `DIMS_MIDSCALE;
		endcase
	endfunction
	task automatic send(input logic [13:0] a, input logic [13:0] b);
		i_dims_source_model.push({a, b});
		expq.push_back(a);
		expq.push_back(second_of(m, a, b));
	endtask
	task automatic drain();
		while (expq.size() > 0 || i_dims_source_model.pend_q.size() > 0)
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask
	task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge clk);
			aw_done = aw_done | (s_axi_awready === 1'b1);
			w_done = w_done | (s_axi_wready === 1'b1);
			s_axi_awvalid <= !aw_done;
			s_axi_wvalid <= !w_done;
		end
		do
			@(posedge clk);
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic axi_rd(input logic [3:0] ad, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, ed);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	// Every converted sample must match the next expected code.
	always @(posedge clk)
	begin
		if (resetn && sample_valid === 1'b1)
		begin
			nsamp++;
			if (hold_out || expq.size() == 0)
				check("spurious_sample", 32'h1, 32'h0);
			else
				check("sample_code", current_out_true, expq.pop_front());
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		seed = 32'h66b4d256;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		axi_rd(`DIMS_ADDR_CTRL, 32'h1, `DIMS_RESP_OKAY);
		axi_rd(4'hc, 32'h0, `DIMS_RESP_SLVERR);
		axi_wr(4'hc, 32'hffffffff, `DIMS_RESP_SLVERR);
		for (m = 0; m < 4; m++)
		begin
			{interleave_sel, single_port_repeat_sel, single_port_invert_sel,
				single_port_zero_stuff_sel} <= 4'b1000 >> m;
			r = $random(seed);
			{loop_restart, clock_invert_sel, out_clock_level_sel} <= r[2:0];
			i_dims_source_model.gap = m;
			repeat (4) @(posedge clk);
			send(`DIMS_ALL_ONES, 14'h0);
			send(14'h0, `DIMS_ALL_ONES);
			for (i = 0; i < 6; i++)
			begin
				r = $random(seed);
				send(r[13:0], r[27:14]);
			end
			drain();
			check("dll_reset", {31'h0, dll_reset}, {31'h0, loop_restart});
		end
		// Asleep the FIFO fills; awake it drains in order.
		m = 3;
		sleep <= 1'b1;
		hold_out <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 32; i++)
		begin
			r = $random(seed);
			send(r[13:0], r[27:14]);
		end
		repeat (300) @(posedge clk);
		check("port_ready", {31'h0, port_ready}, 32'h0);
		check("low_power", {31'h0, low_power}, 32'h1);
		hold_out <= 1'b0;
		sleep <= 1'b0;
		drain();
		axi_rd(`DIMS_ADDR_COUNT, nsamp, `DIMS_RESP_OKAY);
		axi_wr(`DIMS_ADDR_COUNT, 32'h0, `DIMS_RESP_OKAY);
		axi_rd(`DIMS_ADDR_COUNT, 32'h0, `DIMS_RESP_OKAY);
		end_sim();
	end
endmodule // dims_sequencer_test
`default_nettype wire

// >>> tb/dims_source_model.sv
// Purpose: Data source feeding sample pairs into the two differential ports.
// Assumes: The bench queues pairs through push().
// Notes:   Lines are inverted once their hold time has run out.
`timescale 1ns/1ps
`default_nettype none
module dims_source_model (
	// Clock, reset and flow control.
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        port_ready,
	// Differential sample ports.
	output var  logic [13:0] port_a_true,
	output var  logic [13:0] port_a_comp,
	output var  logic [13:0] port_b_true,
	output var  logic [13:0] port_b_comp,
	output var  logic        port_valid
);
	logic [27:0] pend_q[$]; // Pairs waiting, port A in the upper half.
	int          gap = 0;   // Extra idle clocks per pair, for a slow source.
	logic [27:0] pair;      // Pair now on the lines.
	// Queue one pair for sending.
	task automatic push(input logic [27:0] p);
		pend_q.push_back(p);
	endtask
	// ************************************************************
	// Sender
	// ************************************************************
	// One valid pulse per pair; data held so the capture sees it.
	initial
	begin
		port_valid = 1'b0;
		pair = 28'h0;
		{port_a_true, port_b_true} = 28'h0;
		{port_a_comp, port_b_comp} = 28'hfffffff;
		forever
		begin
			@(posedge clk);
			if (resetn && port_ready && pend_q.size() > 0)
			begin
				pair = pend_q.pop_front();
				{port_a_true, port_b_true} <= pair;
				{port_a_comp, port_b_comp} <= ~pair;
				port_valid <= 1'b1;
				@(posedge clk);
				port_valid <= 1'b0;
				repeat (3 + gap) @(posedge clk);
				// Show the inverse so a late capture fails.
				{port_a_true, port_b_true} <= ~pair;
				{port_a_comp, port_b_comp} <= pair;
			end
		end
	end
endmodule // dims_source_model
`default_nettype wire
